/* hdl/sbst_pkg.sv */
// constants, types and carriers shared by the boundary-scan port files
// assumes one test clock domain and one system clock domain
package sbst_pkg;

	// register lengths
	localparam int IR_LEN   = 3;
	localparam int ID_LEN   = 32;
	localparam int BSR_LEN  = 89;
	localparam int RING_LEN = BSR_LEN - 1;

	// instruction codes; 3'h3, 3'h5 and 3'h6 are reserved
	localparam logic [IR_LEN-1:0] IR_EXTEST  = 3'h0;
	localparam logic [IR_LEN-1:0] IR_IDCODE  = 3'h1;
	localparam logic [IR_LEN-1:0] IR_SAMPLEZ = 3'h2;
	localparam logic [IR_LEN-1:0] IR_SAMPLE  = 3'h4;
	localparam logic [IR_LEN-1:0] IR_BYPASS  = 3'h7;

	// values loaded on capture and after reset
	localparam logic [IR_LEN-1:0] IR_CAPT_PAT = 3'h1;
	localparam logic [ID_LEN-1:0] ID_VALUE    = 32'h0a5c_3e11; // arbitrary
	localparam logic              BYP_CAPT    = 1'b0;
	localparam logic              CTL_RST     = 1'b1;
	localparam logic              TDO_RST     = 1'b0;

	// test controller states
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
		ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} sbst_state_t;

	// what the test logic asks of the memory i/o ring
	typedef struct packed {
		logic                test_own;
		logic                out_en;
		logic [RING_LEN-1:0] val;
	} sbst_drive_t;

	localparam sbst_drive_t DRIVE_RST = '{
		test_own: 1'b0,
		out_en:   1'b1,
		val:      '0
	};

endpackage

/* hdl/sbst_bsr.sv */
// boundary scan register: shift stage plus latched parallel stage
// assumes strobes come from the test controller on the same test clock
`timescale 1ns/100ps
module sbst_bsr
	import sbst_pkg::*;
#(
	parameter int LEN = BSR_LEN
) (
	input  wire logic           clk_tck_i,
	input  wire logic           rst_i,
	input  wire logic           capture_i,
	input  wire logic           shift_i,
	input  wire logic           update_i,
	input  wire logic           tdi_i,
	input  wire logic [LEN-2:0] pins_i,
	output logic                so_o,
	output logic      [LEN-1:0] upd_o
);

	typedef struct packed {
		logic [LEN-1:0] sh;
		logic [LEN-1:0] upd;
	} sbst_bsr_st_t;

	sbst_bsr_st_t q;
	sbst_bsr_st_t d;

	////////////////////////////////////////////////////////////////////
	// capture, shift and update of all cells
	always_comb begin
		d = q;
		if (capture_i) begin
			d.sh = {q.upd[LEN-1], pins_i};
		end else if (shift_i) begin
			d.sh = {tdi_i, q.sh[LEN-1:1]};
		end
		if (update_i) begin
			d.upd = q.sh;
		end
	end

	// control cell sits at the top position and presets high
	always_ff @(posedge clk_tck_i) begin
		if (rst_i) begin
			q.sh  <= '0;
			q.upd <= {CTL_RST, {(LEN-1){1'b0}}};
		end else begin
			q <= d;
		end
	end

	assign so_o  = q.sh[0];
	assign upd_o = q.upd;

	////////////////////////////////////////////////////////////////////
	// checks
	a_bsr_shift: assert property (@(posedge clk_tck_i)
		disable iff (rst_i)
		shift_i && !capture_i |=> q.sh[LEN-1] == $past(tdi_i))
		else $error("scan input did not enter the top cell");

	a_bsr_latch: assert property (@(posedge clk_tck_i)
		disable iff (rst_i)
		update_i |=> q.upd == $past(q.sh))
		else $error("update stage did not latch the shift stage");

	a_ctl_preset: assert property (@(posedge clk_tck_i)
		rst_i |=> q.upd[LEN-1] == 1'b1)
		else $error("control cell not preset high");

endmodule

/* hdl/sbst_tap.sv */
// test access port: controller, instruction, bypass, id and scan paths
// assumes tms/tdi are timed to the test clock and ring_i to the system
// clock; the test clock may stop between scans
`timescale 1ns/100ps
module sbst_tap
	import sbst_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                rst_i,
	input  wire logic                clk_tck_i,
	input  wire logic                tms_i,
	input  wire logic                tdi_i,
	output logic                     tdo_o,
	output logic                     tdo_oe_o,
	input  wire logic [RING_LEN-1:0] ring_i,
	output sbst_drive_t              drive_o
);

	////////////////////////////////////////////////////////////////////
	// state types, one per clock edge in use: test clock rising, test clock falling, system clock

	// test clock, rising edge
	typedef struct packed {
		logic                rst_s1;
		logic                rst_s2;
		logic [RING_LEN-1:0] ring_s1;
		logic [RING_LEN-1:0] ring_s2;
		sbst_state_t         st;
		logic [IR_LEN-1:0]   ir_sh;
		logic [IR_LEN-1:0]   ir_q;
		logic                byp;
		logic [ID_LEN-1:0]   id_sh;
	} sbst_tck_st_t;

	// test clock, falling edge
	typedef struct packed {
		logic        tdo;
		logic        oe;
		sbst_drive_t hold;
		logic        tgl;
	} sbst_neg_st_t;

	// system clock
	typedef struct packed {
		logic        tgl_s1;
		logic        tgl_s2;
		logic        tgl_s3;
		sbst_drive_t drive;
	} sbst_sys_st_t;

	////////////////////////////////////////////////////////////////////
	// functions

	// standard controller step on the sampled tms level
	function automatic sbst_state_t tap_next(sbst_state_t s, logic tms);
		sbst_state_t n;
		n = s;
		unique case (s)
			ST_RESET:  n = tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: n = tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
		endcase
		return n;
	endfunction

	// codes that put the boundary register in the data path
	function automatic logic bsr_sel(logic [IR_LEN-1:0] ir);
		return (ir == IR_EXTEST) || (ir == IR_SAMPLEZ) ||
			(ir == IR_SAMPLE);
	endfunction

	////////////////////////////////////////////////////////////////////
	// declarations

	sbst_tck_st_t        tq;
	sbst_tck_st_t        td;
	sbst_neg_st_t        nq;
	sbst_neg_st_t        nd;
	sbst_sys_st_t        sq;
	sbst_sys_st_t        sd;
	logic                rst_t;
	logic                tlr;
	logic                bsr_cap;
	logic                bsr_shf;
	logic                bsr_upd;
	logic                bsr_so;
	logic [BSR_LEN-1:0]  bsr_par;
	logic                dr_bit;
	sbst_drive_t         want;

	// tap-side reset: synchronised system reset only; tlr flags the controller reset state
	assign rst_t = tq.rst_s2;
	assign tlr   = (tq.st == ST_RESET);

	////////////////////////////////////////////////////////////////////
	// boundary scan register strobes, only under the scan codes
	assign bsr_cap = (tq.st == ST_CAP_DR) && bsr_sel(tq.ir_q);
	assign bsr_shf = (tq.st == ST_SH_DR) && bsr_sel(tq.ir_q);
	assign bsr_upd = (tq.st == ST_UPD_DR) && bsr_sel(tq.ir_q);

	// one cell per ring ball plus the output-drive control cell
	sbst_bsr #(
		.LEN       (BSR_LEN)
	) u_bsr (
		.clk_tck_i (clk_tck_i),
		.rst_i     (rst_t || tlr),
		.capture_i (bsr_cap),
		.shift_i   (bsr_shf),
		.update_i  (bsr_upd),
		.tdi_i     (tdi_i),
		.pins_i    (tq.ring_s2),
		.so_o      (bsr_so),
		.upd_o     (bsr_par)
	);

	////////////////////////////////////////////////////////////////////
	// ring control wanted by the active instruction
	always_comb begin
		want = DRIVE_RST;
		unique case (tq.ir_q)
			IR_EXTEST: begin
				want.test_own = 1'b1;
				want.val      = bsr_par[RING_LEN-1:0];
				want.out_en   = bsr_par[BSR_LEN-1];
			end
			IR_SAMPLEZ: begin
				want.out_en = 1'b0;
			end
			default: begin
				want = DRIVE_RST;
			end
		endcase
	end

	// data register bit presented to tdo
	always_comb begin
		if (tq.ir_q == IR_IDCODE) begin
			dr_bit = tq.id_sh[0];
		end else if (bsr_sel(tq.ir_q)) begin
			dr_bit = bsr_so;
		end else begin
			dr_bit = tq.byp;
		end
	end

	////////////////////////////////////////////////////////////////////
	// test clock rising edge: controller and shift paths
	always_comb begin
		td         = tq;
		td.rst_s1  = rst_i;
		td.rst_s2  = tq.rst_s1;
		td.ring_s1 = ring_i;
		td.ring_s2 = tq.ring_s1;
		if (tq.rst_s2) begin
			td.st    = ST_RESET;
			td.ir_sh = IR_CAPT_PAT;
			td.ir_q  = IR_IDCODE;
			td.byp   = BYP_CAPT;
			td.id_sh = ID_VALUE;
		end else begin
			td.st = tap_next(tq.st, tms_i);
			unique case (tq.st)
				ST_RESET: begin
					td.ir_q = IR_IDCODE;
				end
				ST_CAP_IR: begin
					td.ir_sh = IR_CAPT_PAT;
				end
				ST_SH_IR: begin
					td.ir_sh = {tdi_i, tq.ir_sh[IR_LEN-1:1]};
				end
				ST_UPD_IR: begin
					td.ir_q = tq.ir_sh;
				end
				ST_CAP_DR: begin
					td.byp   = BYP_CAPT;
					td.id_sh = ID_VALUE;
				end
				ST_SH_DR: begin
					td.byp   = tdi_i;
					td.id_sh = {tdi_i, tq.id_sh[ID_LEN-1:1]};
				end
				default: begin
					td.byp = tq.byp;
				end
			endcase
		end
	end

	always_ff @(posedge clk_tck_i) begin
		tq <= td;
	end

	////////////////////////////////////////////////////////////////////
	// test clock falling edge: tdo, its enable and the ring control word;
	// the fall after an update publishes the word even if the test clock
	// then stops, so no extra test clock is needed to apply it
	always_comb begin
		nd = nq;
		if (rst_t) begin
			nd.tdo  = TDO_RST;
			nd.oe   = 1'b0;
			nd.hold = DRIVE_RST;
			nd.tgl  = 1'b0;
		end else begin
			nd.oe = (tq.st == ST_SH_IR) || (tq.st == ST_SH_DR);
			if (tq.st == ST_SH_IR) begin
				nd.tdo = tq.ir_sh[0];
			end else if (tq.st == ST_SH_DR) begin
				nd.tdo = dr_bit;
			end else begin
				nd.tdo = nq.tdo;
			end
			// publish a new ring control word with a toggle
			if (want != nq.hold) begin
				nd.hold = want;
				nd.tgl  = ~nq.tgl;
			end
		end
	end

	always_ff @(negedge clk_tck_i) begin
		nq <= nd;
	end

	assign tdo_o    = nq.tdo;
	assign tdo_oe_o = nq.oe;

	////////////////////////////////////////////////////////////////////
	// system clock: take the held control word after the toggle settles
	always_comb begin
		sd        = sq;
		sd.tgl_s1 = nq.tgl;
		sd.tgl_s2 = sq.tgl_s1;
		sd.tgl_s3 = sq.tgl_s2;
		if (rst_i) begin
			sd.drive = DRIVE_RST;
		end else if (sq.tgl_s2 != sq.tgl_s3) begin
			sd.drive = nq.hold; // word is stable for a whole test cycle
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sq.tgl_s1 <= 1'b0;
			sq.tgl_s2 <= 1'b0;
			sq.tgl_s3 <= 1'b0;
			sq.drive  <= DRIVE_RST;
		end else begin
			sq <= sd;
		end
	end

	assign drive_o = sq.drive;

	////////////////////////////////////////////////////////////////////
	// checks
	sequence s_tms_high5;
		tms_i [*5];
	endsequence

	a_tlr_five: assert property (@(posedge clk_tck_i)
		disable iff (rst_t) s_tms_high5 |=> tq.st == ST_RESET)
		else $error("five high tms edges did not reset the controller");

	a_capir_pattern: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.st == ST_CAP_IR |=> tq.ir_sh[1:0] == 2'b01)
		else $error("capture-ir pattern wrong");

	a_ir_update: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.st == ST_UPD_IR |=> tq.ir_q == $past(tq.ir_sh))
		else $error("instruction not taken at update-ir");

	a_ir_held: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.st != ST_UPD_IR && tq.st != ST_RESET |=> $stable(tq.ir_q))
		else $error("instruction changed outside update-ir");

	a_tlr_idcode: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tlr |=> tq.ir_q == IR_IDCODE)
		else $error("id instruction not active after reset state");

	a_byp_clear: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.st == ST_CAP_DR && tq.ir_q == IR_BYPASS |=> !tq.byp)
		else $error("bypass stage not cleared on capture");

	a_id_load: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.st == ST_CAP_DR |=> tq.id_sh == ID_VALUE)
		else $error("id code not loaded on capture");

	// system reset also masks the start-up edges before the sync settles
	a_tdo_window: assert property (@(posedge clk_tck_i)
		disable iff (rst_i || rst_t)
		tdo_oe_o == (tq.st == ST_SH_IR || tq.st == ST_SH_DR))
		else $error("tdo enable outside shift states");

	a_highz_want: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.ir_q == IR_SAMPLEZ |-> !nq.hold.out_en)
		else $error("outputs not floated under high-z sample");

	a_extest_ctl: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.ir_q == IR_EXTEST |-> nq.hold.out_en == bsr_par[BSR_LEN-1])
		else $error("control cell not steering output enable");

	a_sample_quiet: assert property (@(posedge clk_tck_i)
		disable iff (rst_t)
		tq.ir_q == IR_SAMPLE || tq.ir_q == IR_BYPASS |-> !nq.hold.test_own)
		else $error("memory disturbed under sample or bypass");

endmodule

/* dv/sbst_ctl_model.sv */
// behavioural board-level scan controller that drives the test port
// assumes the bench resolves the tdo pin to z while it is not driven
`timescale 1ns/100ps
module sbst_ctl_model (
	output logic      clk_tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i
);

	////////////////////////////////////////////////////////////////////
	// idle levels: clock parked low, tms and tdi at their pull-up level
	initial begin
		clk_tck_o = 1'b0;
		tms_o     = 1'b1;
		tdi_o     = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// one test clock period of 80 ns, below the 20 mhz ceiling
	task automatic pulse(input logic tms, input logic tdi,
		output logic seen);
		tms_o     = tms;
		tdi_o     = tdi;
		#40;
		seen      = tdo_i;
		clk_tck_o = 1'b1;
		#40;
		clk_tck_o = 1'b0;
	endtask

	// five high tms edges reach test-logic-reset, then park in idle
	task automatic tlr();
		logic s;
		#3.3;
		repeat (5) pulse(1'b1, 1'b1, s);
		pulse(1'b0, 1'b1, s);
	endtask

	// full ir or dr scan from idle back to idle, lsb out first
	task automatic scan(input logic ir, input int len,
		input logic [88:0] din, output logic [88:0] dout);
		logic s;
		int   i;
		dout = '0;
		#3.3; // clock stands still between frames, phase is free
		pulse(1'b1, 1'b1, s);
		if (ir) begin
			pulse(1'b1, 1'b1, s);
		end
		pulse(1'b0, 1'b1, s);
		pulse(1'b0, 1'b1, s);
		for (i = 0; i < len; i++) begin
			pulse(i == len - 1, din[i], s);
			dout[i] = s;
		end
		pulse(1'b1, 1'b1, s);
		pulse(1'b0, 1'b1, s);
	endtask

endmodule

/* dv/tb_top.sv */
// self-checking bench for the boundary-scan test port
// assumes the scan controller model owns the test clock
`timescale 1ns/100ps
module tb_top
	import sbst_pkg::*;
;

	localparam logic [RING_LEN-1:0] RING_PAT = 88'ha5c3_96e1_0f87_d24b_3c19_e6;

	logic                clk_sys_i;
	logic                rst_i;
	logic [RING_LEN-1:0] ring_i;
	logic                clk_tck;
	logic                tms;
	logic                tdi;
	logic                tdo;
	logic                tdo_oe;
	wire                 tdo_pin;
	sbst_drive_t         drive;
	int                  bad_count;
	int                  total_checks;

	////////////////////////////////////////////////////////////////////
	// clocks, pin resolution, design and controller model
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	assign tdo_pin = tdo_oe ? tdo : 1'bz; // released pin floats

	sbst_tap i_dut (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.clk_tck_i (clk_tck),
		.tms_i     (tms),
		.tdi_i     (tdi),
		.tdo_o     (tdo),
		.tdo_oe_o  (tdo_oe),
		.ring_i    (ring_i),
		.drive_o   (drive)
	);

	sbst_ctl_model i_ctl (
		.clk_tck_o (clk_tck),
		.tms_o     (tms),
		.tdi_o     (tdi),
		.tdo_i     (tdo_pin)
	);

	////////////////////////////////////////////////////////////////////
	// comparison, verdict and helpers
	task automatic check(input string what, input logic [127:0] seen,
		input logic [127:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// every instruction load also checks the captured ir pattern
	task automatic load_ir(input logic [IR_LEN-1:0] code);
		logic [88:0] o;
		i_ctl.scan(1'b1, IR_LEN, 89'(code), o);
		check("ir capture", o[2:0], IR_CAPT_PAT);
	endtask

	// lets the drive word cross into the system domain
	task automatic settle();
		repeat (24) @(posedge clk_sys_i);
	endtask

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_after_reset();
		logic [88:0] o;
		check("tdo idle", tdo_pin, 1'bz);
		check("drive reset", drive, DRIVE_RST);
		i_ctl.scan(1'b0, ID_LEN, '0, o);
		check("id value", o[31:0], ID_VALUE);
	endtask

	task automatic t_all_codes();
		logic [88:0] o;
		logic [7:0]  e;
		int          c;
		for (c = 0; c < 8; c++) begin
			load_ir(c[2:0]);
			i_ctl.scan(1'b0, 8, 89'h5a, o);
			case (c[2:0])
				IR_IDCODE:                     e = ID_VALUE[7:0];
				IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE: e = RING_PAT[7:0];
				default:                       e = 8'hb4; // bypass path
			endcase
			check("dr head", o[7:0], e);
		end
	endtask

	task automatic t_preload_extest();
		logic [88:0] o;
		logic [88:0] p;
		logic [88:0] q;
		p = {1'b1, ~RING_PAT};
		q = {1'b0, RING_PAT[43:0], RING_PAT[87:44]};
		load_ir(IR_SAMPLE);
		i_ctl.scan(1'b0, BSR_LEN, p, o);
		check("ring capture", o[87:0], RING_PAT);
		i_ctl.scan(1'b0, BSR_LEN, q, o);
		check("capture pass", o, {p[88], RING_PAT});
		check("sample quiet", drive, DRIVE_RST);
		load_ir(IR_EXTEST);
		settle();
		check("extest drive", drive, {1'b1, q});
		load_ir(IR_SAMPLEZ);
		settle();
		check("highz drive", {drive.test_own, drive.out_en}, 2'h0);
	endtask

	task automatic t_tap_reset();
		logic [88:0] o;
		i_ctl.tlr();
		settle();
		check("tlr drive", drive, DRIVE_RST);
		check("tlr tdo", tdo_pin, 1'bz);
		i_ctl.scan(1'b0, ID_LEN, '0, o);
		check("tlr id", o[31:0], ID_VALUE);
		load_ir(IR_EXTEST);
		settle();
		check("preset cell", drive, {2'h3, {RING_LEN{1'b0}}});
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence: reset spans several test clocks so both sides clear
	initial begin
		bad_count    = 0;
		total_checks = 0;
		rst_i        = 1'b1;
		ring_i       = RING_PAT;
		i_ctl.tlr();
		@(posedge clk_sys_i);
		rst_i <= 1'b0;
		i_ctl.tlr();
		settle();
		t_after_reset();
		t_all_codes();
		t_preload_extest();
		t_tap_reset();
		give_verdict();
	end

	// watchdog, about five times the forty microseconds the scans take
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end

endmodule
